// File: rtl/pgp_cfg.svh
// Constants for the serial programming port: fields, pin indices, timing
`ifndef PGP_CFG_SVH
`define PGP_CFG_SVH

// ****************************************************************
// Command and response word layout
// ****************************************************************
`define PGP_WORD_W 32
`define PGP_WORD_MSB 31
`define PGP_SEL_DATA 29
`define PGP_SEL_CODE 28
`define PGP_DIR_BIT 24
`define PGP_ADDR_HI 17
`define PGP_ADDR_LO 8
`define PGP_DATA_HI 7
`define PGP_DATA_LO 0
`define PGP_UPPER_W 14
`define PGP_ADDR_W 10
`define PGP_DATA_W 8
`define PGP_RESP_RST 32'h0000_0000

// ****************************************************************
// Device pin synchroniser slots
// ****************************************************************
`define PGP_IN_HV 0
`define PGP_IN_LOAD 1
`define PGP_IN_SDI 2
`define PGP_IN_SCK 3
`define PGP_IN_N 4

// ****************************************************************
// Timing, system clock 100 MHz
// ****************************************************************
`define PGP_CLK_NS 10
`define PGP_SCK_HALF_NS 2000
`define PGP_ACCESS_NS 1000
`define PGP_HV_NS 10000
`define PGP_SCK_HALF ((`PGP_SCK_HALF_NS + `PGP_CLK_NS - 1) / `PGP_CLK_NS)
`define PGP_ACCESS_CYC ((`PGP_ACCESS_NS + `PGP_CLK_NS - 1) / `PGP_CLK_NS)
`define PGP_HV_CYC ((`PGP_HV_NS + `PGP_CLK_NS - 1) / `PGP_CLK_NS)
`define PGP_CNT_W 10
`define PGP_BIT_W 6
`define PGP_LAST_BIT 31
`define PGP_EXEC_PULSES 2

// ****************************************************************
// Command buffer
// ****************************************************************
`define PGP_FIFO_DEPTH 8

`endif

// File: rtl/pgp_pkg.sv
// Types shared by both ends of the serial programming port
`default_nettype none

package pgp_pkg;

  typedef enum logic [2:0] {
    DEV_OFF,
    DEV_ENTRY,
    DEV_SHIFT,
    DEV_EXEC,
    DEV_BUSY,
    DEV_DONE
  } pgp_dev_st_t;

  typedef enum logic [2:0] {
    PRG_IDLE,
    PRG_HV,
    PRG_READY,
    PRG_SHIFT,
    PRG_EXEC,
    PRG_HS
  } pgp_prg_st_t;

endpackage : pgp_pkg

`default_nettype wire

// File: rtl/pgp_link_if.sv
// Four-wire programming link between programmer and device
`timescale 1ns/1ns
`default_nettype none

interface pgp_link_if;
  logic load_hv;
  logic load;
  logic sdi;
  logic sck;
  logic sdo;

  modport dev (
    input load_hv,
    input load,
    input sdi,
    input sck,
    output sdo
  );

  modport prog (
    output load_hv,
    output load,
    output sdi,
    output sck,
    input sdo
  );
endinterface : pgp_link_if

`default_nettype wire

// File: rtl/pgp_dev.sv
// Device end of the serial programming port with memory access port
// Functional notes
// RULE1 - Four lines: load, data in, data out, clock
// RULE2 - Programmer enters mode with super-voltage load
// RULE3 - Load back high, then 32 command bits
// RULE4 - Bit 31 shifted first
// RULE5 - Previous response shifts out during command
// RULE6 - First response after entry is undefined
// RULE7 - Load low, two clock pulses execute
// RULE8 - Data out low by second exec edge
// RULE9 - Write done sets ready, data out high
// RULE10 - Programmer waits data out high before load
// RULE11 - Read byte latched after second exec edge
// RULE12 - Bit 29 data, bit 28 code array
// RULE13 - Bit 24: one read, zero write
// RULE14 - Bits 17..8 address, echoed in response
// RULE15 - Bits 7..0 write data or read byte
// RULE16 - Block reads check each following response
// RULE17 - Addresses equal normal-operation addresses
// RULE18 - Mode left only at power down
// RULE19 - Response loaded before next shift phase
`timescale 1ns/1ns
`default_nettype none
`include "pgp_cfg.svh"

module pgp_dev (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  pgp_link_if.dev link,
  output logic prog_mode_o,
  output logic ready_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_sel_data_o,
  output logic mem_sel_code_o,
  output logic [`PGP_ADDR_W-1:0] mem_addr_o,
  output logic [`PGP_DATA_W-1:0] mem_wdata_o,
  input wire logic [`PGP_DATA_W-1:0] mem_rdata_i,
  input wire logic mem_ack_i
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pgp_pkg::pgp_dev_st_t st;
    logic [`PGP_IN_N-1:0] s1;
    logic [`PGP_IN_N-1:0] s2;
    logic sck_d;
    logic [1:0] edges;
    logic [`PGP_WORD_W-1:0] cmd;
    logic [`PGP_WORD_W-1:0] resp;
    logic prog_mode;
    logic ready;
    logic sdo;
    logic mem_req;
    logic mem_we;
    logic sel_data;
    logic sel_code;
    logic [`PGP_ADDR_W-1:0] addr;
    logic [`PGP_DATA_W-1:0] wdata;
  } pgp_dev_state_t;

  pgp_dev_state_t s_reg;
  pgp_dev_state_t s_next;

  logic hv;
  logic load;
  logic sdi;
  logic sck_rise;
  logic sck_fall;

  // Response word: upper bits read as zero, address echoed
  function automatic logic [`PGP_WORD_W-1:0] resp_word(
    input logic [`PGP_ADDR_W-1:0] addr,
    input logic [`PGP_DATA_W-1:0] data
  );
    resp_word = {{`PGP_UPPER_W{1'b0}}, addr, data}; // RULE14 RULE15
  endfunction : resp_word

  // Only one array may be named; otherwise no access is made
  function automatic logic sel_ok(input logic [`PGP_WORD_W-1:0] c);
    sel_ok = c[`PGP_SEL_DATA] ^ c[`PGP_SEL_CODE]; // RULE12
  endfunction : sel_ok

  // Pins are read only from the second synchroniser stage
  assign hv = s_reg.s2[`PGP_IN_HV];
  assign load = s_reg.s2[`PGP_IN_LOAD];
  assign sdi = s_reg.s2[`PGP_IN_SDI];
  assign sck_rise = s_reg.s2[`PGP_IN_SCK] & ~s_reg.sck_d;
  assign sck_fall = ~s_reg.s2[`PGP_IN_SCK] & s_reg.sck_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.s1 = {link.sck, link.sdi, link.load, link.load_hv}; // RULE1
    s_next.s2 = s_reg.s1;
    s_next.sck_d = s_reg.s2[`PGP_IN_SCK];
    unique case (s_reg.st)
      pgp_pkg::DEV_OFF:
      begin
        s_next.sdo = 1'b1;
        if (hv)
        begin
          s_next.prog_mode = 1'b1;
          s_next.st = pgp_pkg::DEV_ENTRY;
        end
      end
      pgp_pkg::DEV_ENTRY:
      begin
        // Response register keeps its reset value: content undefined
        if (!hv && load) // RULE6
        begin
          s_next.st = pgp_pkg::DEV_SHIFT;
          s_next.sdo = s_reg.resp[`PGP_WORD_MSB];
        end
      end
      pgp_pkg::DEV_SHIFT:
      begin
        // Sample on rise, shift out on fall so the programmer's
        // late sample after each rise sees a settled bit
        if (sck_rise)
        begin
          s_next.cmd = {s_reg.cmd[`PGP_WORD_MSB-1:0], sdi}; // RULE4
        end
        if (sck_fall)
        begin
          s_next.resp = {s_reg.resp[`PGP_WORD_MSB-1:0], 1'b0}; // RULE5
        end
        s_next.sdo = s_next.resp[`PGP_WORD_MSB]; // RULE5
        if (!load)
        begin
          s_next.st = pgp_pkg::DEV_EXEC; // RULE7
          s_next.edges = 2'h0;
          s_next.ready = 1'b0;
        end
      end
      pgp_pkg::DEV_EXEC:
      begin
        if (sck_rise)
        begin
          s_next.edges = s_reg.edges + 2'h1;
          s_next.sdo = 1'b0; // RULE8
          if (s_reg.edges == 2'(`PGP_EXEC_PULSES - 1))
          begin
            s_next.addr = s_reg.cmd[`PGP_ADDR_HI:`PGP_ADDR_LO]; // RULE17
            s_next.wdata = s_reg.cmd[`PGP_DATA_HI:`PGP_DATA_LO];
            s_next.mem_we = ~s_reg.cmd[`PGP_DIR_BIT]; // RULE13
            s_next.sel_data = s_reg.cmd[`PGP_SEL_DATA]; // RULE12
            s_next.sel_code = s_reg.cmd[`PGP_SEL_CODE];
            if (sel_ok(s_reg.cmd))
            begin
              s_next.mem_req = 1'b1;
              s_next.st = pgp_pkg::DEV_BUSY;
            end
            else
            begin
              // Neither or both arrays named: complete at once with a zero byte
              s_next.resp = resp_word(s_reg.cmd[`PGP_ADDR_HI:`PGP_ADDR_LO],
                `PGP_DATA_W'(0));
              s_next.ready = 1'b1;
              s_next.sdo = 1'b1;
              s_next.st = pgp_pkg::DEV_DONE;
            end
          end
        end
      end
      pgp_pkg::DEV_BUSY:
      begin
        if (mem_ack_i)
        begin
          s_next.mem_req = 1'b0;
          if (s_reg.mem_we)
          begin
            s_next.resp = resp_word(s_reg.addr, s_reg.wdata); // RULE15 RULE19
          end
          else
          begin
            s_next.resp = resp_word(s_reg.addr, mem_rdata_i); // RULE11 RULE19
          end
          s_next.ready = 1'b1; // RULE9
          s_next.sdo = 1'b1; // RULE9
          s_next.st = pgp_pkg::DEV_DONE;
        end
      end
      pgp_pkg::DEV_DONE:
      begin
        // Programmer raises load only after seeing the handshake high
        if (load && !hv) // RULE10
        begin
          s_next.sdo = s_reg.resp[`PGP_WORD_MSB];
          s_next.st = pgp_pkg::DEV_SHIFT; // RULE3
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset stands for power-up: nothing else clears the mode
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '{
        st: pgp_pkg::DEV_OFF,
        s1: '0,
        s2: '0,
        sck_d: 1'b0,
        edges: 2'h0,
        cmd: '0,
        resp: `PGP_RESP_RST,
        prog_mode: 1'b0,
        ready: 1'b0,
        sdo: 1'b1,
        mem_req: 1'b0,
        mem_we: 1'b0,
        sel_data: 1'b0,
        sel_code: 1'b0,
        addr: '0,
        wdata: '0
      }; // RULE18
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.sdo = s_reg.sdo;
  assign prog_mode_o = s_reg.prog_mode;
  assign ready_o = s_reg.ready;
  assign mem_req_o = s_reg.mem_req;
  assign mem_we_o = s_reg.mem_we;
  assign mem_sel_data_o = s_reg.sel_data;
  assign mem_sel_code_o = s_reg.sel_code;
  assign mem_addr_o = s_reg.addr;
  assign mem_wdata_o = s_reg.wdata;

endmodule : pgp_dev

`default_nettype wire

// File: rtl/pgp_prog.sv
// Programmer end of the serial programming port, with command FIFO
`timescale 1ns/1ns
`default_nettype none
`include "pgp_cfg.svh"

// ****************************************************************
// Command FIFO
// ****************************************************************
module pgp_fifo #(
  parameter int WIDTH = `PGP_WORD_W,
  parameter int DEPTH = `PGP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic in_rdy;
    logic out_vld;
  } pgp_fifo_state_t;

  pgp_fifo_state_t f_reg;
  pgp_fifo_state_t f_next;
  logic push;
  logic pop;

  assign push = in_valid_i & f_reg.in_rdy;
  assign pop = out_ready_i & f_reg.out_vld;

  always_comb
  begin
    f_next = f_reg;
    if (push)
    begin
      f_next.mem[f_reg.wr] = in_data_i;
      f_next.wr = (f_reg.wr == AW'(DEPTH - 1)) ? '0 : f_reg.wr + AW'(1);
    end
    if (pop)
    begin
      f_next.rd = (f_reg.rd == AW'(DEPTH - 1)) ? '0 : f_reg.rd + AW'(1);
    end
    f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    f_next.in_rdy = f_next.cnt != (AW+1)'(DEPTH);
    f_next.out_vld = f_next.cnt != '0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      f_reg <= '{mem: '0, wr: '0, rd: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
    end
    else
    begin
      f_reg <= f_next;
    end
  end

  assign in_ready_o = f_reg.in_rdy;
  assign out_valid_o = f_reg.out_vld;
  assign out_data_o = f_reg.mem[f_reg.rd];
endmodule : pgp_fifo

// ****************************************************************
// Programmer
// ****************************************************************
module pgp_prog (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  pgp_link_if.prog link,
  input wire logic start_i,
  input wire logic cmd_valid_i,
  input wire logic [`PGP_WORD_W-1:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [`PGP_WORD_W-1:0] rsp_data_o,
  output logic prog_mode_o
);
  typedef struct packed {
    pgp_pkg::pgp_prg_st_t st;
    logic sdo_s1;
    logic sdo_s2;
    logic [`PGP_CNT_W-1:0] cnt;
    logic [`PGP_BIT_W-1:0] bitn;
    logic hv;
    logic load;
    logic sck;
    logic sdi;
    logic [`PGP_WORD_W-1:0] cmd;
    logic [`PGP_WORD_W-1:0] rx;
    logic first;
    logic rsp_valid;
    logic [`PGP_WORD_W-1:0] rsp_data;
    logic prog_mode;
  } pgp_prg_state_t;

  localparam logic [`PGP_CNT_W-1:0] HALF_M1 = `PGP_CNT_W'(`PGP_SCK_HALF - 1);
  localparam logic [`PGP_CNT_W-1:0] SAMP = `PGP_CNT_W'(`PGP_SCK_HALF + `PGP_ACCESS_CYC - 1);
  localparam logic [`PGP_CNT_W-1:0] PER_M1 = `PGP_CNT_W'(2 * `PGP_SCK_HALF - 1);
  localparam logic [`PGP_CNT_W-1:0] HV_M1 = `PGP_CNT_W'(`PGP_HV_CYC - 1);

  pgp_prg_state_t p_reg;
  pgp_prg_state_t p_next;
  logic q_valid;
  logic [`PGP_WORD_W-1:0] q_data;
  logic q_pop;

  assign q_pop = (p_reg.st == pgp_pkg::PRG_READY) & q_valid;

  pgp_fifo #(.WIDTH(`PGP_WORD_W), .DEPTH(`PGP_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .in_valid_i(cmd_valid_i),
    .in_data_i(cmd_data_i),
    .in_ready_o(cmd_ready_o),
    .out_valid_o(q_valid),
    .out_data_o(q_data),
    .out_ready_i(q_pop)
  );

  always_comb
  begin
    p_next = p_reg;
    p_next.sdo_s1 = link.sdo;
    p_next.sdo_s2 = p_reg.sdo_s1;
    p_next.rsp_valid = 1'b0;
    unique case (p_reg.st)
      pgp_pkg::PRG_IDLE:
      begin
        if (start_i)
        begin
          p_next.hv = 1'b1; // RULE2
          p_next.load = 1'b1;
          p_next.cnt = '0;
          p_next.prog_mode = 1'b1;
          p_next.st = pgp_pkg::PRG_HV;
        end
      end
      pgp_pkg::PRG_HV:
      begin
        p_next.cnt = p_reg.cnt + `PGP_CNT_W'(1);
        if (p_reg.cnt == HV_M1)
        begin
          p_next.hv = 1'b0; // RULE3
          p_next.first = 1'b1;
          p_next.st = pgp_pkg::PRG_READY;
        end
      end
      pgp_pkg::PRG_READY:
      begin
        if (q_valid)
        begin
          p_next.cmd = q_data;
          p_next.sdi = q_data[`PGP_WORD_MSB];
          p_next.cnt = '0;
          p_next.bitn = '0;
          p_next.st = pgp_pkg::PRG_SHIFT;
        end
      end
      pgp_pkg::PRG_SHIFT:
      begin
        p_next.cnt = p_reg.cnt + `PGP_CNT_W'(1);
        if (p_reg.cnt == HALF_M1)
        begin
          p_next.sck = 1'b1;
        end
        // Sample the response a full access time after the rise
        if (p_reg.cnt == SAMP)
        begin
          p_next.rx = {p_reg.rx[`PGP_WORD_MSB-1:0], p_reg.sdo_s2};
        end
        if (p_reg.cnt == PER_M1)
        begin
          p_next.sck = 1'b0;
          p_next.cnt = '0;
          p_next.bitn = p_reg.bitn + `PGP_BIT_W'(1);
          p_next.cmd = {p_reg.cmd[`PGP_WORD_MSB-1:0], 1'b0};
          p_next.sdi = p_reg.cmd[`PGP_WORD_MSB-1];
          if (p_reg.bitn == `PGP_BIT_W'(`PGP_LAST_BIT))
          begin
            p_next.load = 1'b0; // RULE7
            p_next.bitn = '0;
            p_next.st = pgp_pkg::PRG_EXEC;
          end
        end
      end
      pgp_pkg::PRG_EXEC:
      begin
        p_next.cnt = p_reg.cnt + `PGP_CNT_W'(1);
        if (p_reg.cnt == HALF_M1)
        begin
          p_next.sck = 1'b1;
        end
        if (p_reg.cnt == PER_M1)
        begin
          p_next.sck = 1'b0;
          p_next.cnt = '0;
          p_next.bitn = p_reg.bitn + `PGP_BIT_W'(1);
          if (p_reg.bitn == `PGP_BIT_W'(`PGP_EXEC_PULSES - 1))
          begin
            p_next.st = pgp_pkg::PRG_HS;
          end
        end
      end
      pgp_pkg::PRG_HS:
      begin
        if (p_reg.sdo_s2)
        begin
          p_next.load = 1'b1; // RULE10
          p_next.rsp_valid = ~p_reg.first; // RULE6
          p_next.rsp_data = p_reg.rx;
          p_next.first = 1'b0;
          p_next.st = pgp_pkg::PRG_READY;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      p_reg <= '{st: pgp_pkg::PRG_IDLE, sdo_s1: 1'b0, sdo_s2: 1'b0, cnt: '0, bitn: '0,
        hv: 1'b0, load: 1'b0, sck: 1'b0, sdi: 1'b0, cmd: '0, rx: '0, first: 1'b1,
        rsp_valid: 1'b0, rsp_data: '0, prog_mode: 1'b0};
    end
    else
    begin
      p_reg <= p_next;
    end
  end

  assign link.load_hv = p_reg.hv;
  assign link.load = p_reg.load;
  assign link.sck = p_reg.sck;
  assign link.sdi = p_reg.sdi;
  assign rsp_valid_o = p_reg.rsp_valid;
  assign rsp_data_o = p_reg.rsp_data;
  assign prog_mode_o = p_reg.prog_mode;
endmodule : pgp_prog

`default_nettype wire

// File: rtl/pgp_dev_pad.sv
// Intentionally empty

// File: dv/pgp_link_sva.sv
// Link protocol checker for the serial programming port
`timescale 1ns/1ns
`default_nettype none

module pgp_link_sva (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic load_hv,
  input wire logic load,
  input wire logic sdi,
  input wire logic sck,
  input wire logic sdo
);
  logic load_q;
  logic sck_q;
  logic [5:0] bit_cnt;
  logic [2:0] ex_cnt;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // Counters saturate so a runaway clock cannot wrap back to a legal value
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      load_q <= 1'b0;
      sck_q <= 1'b0;
      bit_cnt <= 6'h00;
      ex_cnt <= 3'h0;
    end
    else
    begin
      load_q <= load;
      sck_q <= sck;
      if (load && !load_q)
        bit_cnt <= 6'h00;
      else if (load && sck && !sck_q && bit_cnt != 6'h3f)
        bit_cnt <= bit_cnt + 6'h01;
      if (load)
        ex_cnt <= 3'h0;
      else if (sck && !sck_q && ex_cnt != 3'h7)
        ex_cnt <= ex_cnt + 3'h1;
    end
  end

  a_hv_ends_high: assert property ($fell(load_hv) |-> load)
    else $error("load not high when super voltage ends");
  a_hv_no_clock: assert property (load_hv |-> !sck)
    else $error("link clock runs during super voltage");
  a_word_bits: assert property ($fell(load) |-> bit_cnt == 6'h20)
    else $error("command frame not 32 clocks long");
  a_exec_pulses: assert property (!load |-> ex_cnt <= 3'h2)
    else $error("more than two execute pulses");
  a_busy_low: assert property (!load && sck && !sck_q |-> ##[0:8] !sdo)
    else $error("handshake not low after execute clock");
  a_load_waits: assert property ($rose(load) |-> $past(sdo, 2))
    else $error("load raised while handshake low");
  a_sdi_steady: assert property ($changed(sdi) |-> !sck)
    else $error("command bit changed while clock high");
  a_sck_high: assert property ($rose(sck) |-> sck [*8])
    else $error("link clock high phase too short");
  a_done_stands: assert property ($rose(sdo) && !load |=> sdo [*2])
    else $error("handshake release did not hold");
endmodule : pgp_link_sva

`default_nettype wire

// File: dv/serial_eeprom_programming_port_tb.sv
// Bench joining programmer and device over the link, with memory model
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_programming_port_tb;
  // Six commands of about 14000 cycles each
  localparam int LIMIT = 98000;
  logic clk, nrst, start, cmd_valid, cmd_ready, rsp_valid, prg_mode, dev_mode, dev_ready;
  logic mem_req, mem_we, sel_d, sel_c, mem_ack;
  logic [31:0] cmd_data, rsp_data, seed, word;
  logic [9:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] mem [2][1024];
  logic [7:0] sh [2][1024];
  logic [31:0] exp_q[$], rsp_q[$], fq[$];
  logic [20:0] acc_q[$];
  int failures, checked, cyc, dly, n;

  pgp_link_if link ();
  pgp_prog i_pgp_prog (.clk_sys_i(clk), .nrst_i(nrst), .link(link), .start_i(start),
    .cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .prog_mode_o(prg_mode));
  pgp_dev i_pgp_dev (.clk_sys_i(clk), .nrst_i(nrst), .link(link), .prog_mode_o(dev_mode),
    .ready_o(dev_ready), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_sel_data_o(sel_d),
    .mem_sel_code_o(sel_c), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
  pgp_link_sva i_pgp_link_sva (.clk_sys_i(clk), .nrst_i(nrst), .load_hv(link.load_hv),
    .load(link.load), .sdi(link.sdi), .sck(link.sck), .sdo(link.sdo));

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : lfsr

  function automatic logic [31:0] mk(input logic [1:0] s, input logic rd,
    input logic [9:0] a, input logic [7:0] d);
    return {2'h0, s, 3'h0, rd, 6'h00, a, d};
  endfunction : mk

  // Invalid array select answers with a zero byte and no access
  function automatic logic [31:0] expect_rsp(input logic [31:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c[29] != c[28])
    begin
      if (c[24])
        d = sh[c[28]][c[17:8]];
      else
        d = c[7:0];
      sh[c[28]][c[17:8]] = d;
    end
    return {14'h0000, c[17:8], d};
  endfunction : expect_rsp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic push(input logic [31:0] c);
    exp_q.push_back(expect_rsp(c));
    fq.push_back(c);
    if (c[29] != c[28])
      acc_q.push_back({c[29:28], ~c[24], c[17:0]});
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_data = c;
    while (cmd_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : push

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      failures++;
      close_out();
    end
  end

  always @(negedge clk)
  begin
    if (rsp_valid === 1'b1)
      rsp_q.push_back(rsp_data);
  end

  // Commands leave the buffer in order and cross the link bit 31 first
  always @(posedge link.sck)
  begin
    if (link.load === 1'b1)
      word = {word[30:0], link.sdi};
  end

  always @(negedge link.load)
  begin
    if (nrst === 1'b1)
      check("fifo_data", word, fq.pop_front());
  end

  // ****************************************************************
  // Memory behind the device, random latency
  // ****************************************************************
  always @(negedge clk)
  begin
    if (mem_req === 1'b1 && mem_ack === 1'b0 && dly == 0)
    begin
      check("mem_access", 32'({sel_d, sel_c, mem_we, mem_addr, mem_wdata}),
        32'(acc_q.pop_front()));
      mem_rdata = mem[sel_c][mem_addr];
      if (mem_we === 1'b1)
        mem[sel_c][mem_addr] = mem_wdata;
      mem_ack = 1'b1;
      dly = int'(lfsr() % 4);
    end
    else
    begin
      mem_ack = 1'b0;
      if (mem_req === 1'b1 && dly > 0)
        dly--;
    end
  end

  initial
  begin
    logic [31:0] v;
    {nrst, start, cmd_valid, cmd_data, mem_rdata, mem_ack} = '0;
    seed = 32'ha075;
    dly = 0;
    for (int i = 0; i < 1024; i++)
    begin
      v = lfsr();
      {mem[0][i], mem[1][i]} = v[15:0];
      {sh[0][i], sh[1][i]} = v[15:0];
    end
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    // ****************************************************************
    // Buffer: fill through the idle programmer, then clear by reset
    // ****************************************************************
    n = 0;
    repeat (10)
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_data = lfsr();
      if (cmd_ready === 1'b1)
        n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    check("fifo_fill", 32'(n), 32'h8);
    check("fifo_full", 32'(cmd_ready), 32'h0);
    // Draining eight words over the link would cost too many cycles
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check("fifo_empty", 32'({cmd_ready, prg_mode, dev_mode}), 32'h4);
    nrst = 1'b1;
    $display("fifo test done");
    // ****************************************************************
    // Link: writes, reads, refused selects, boundary address
    // ****************************************************************
    v = lfsr();
    push(mk(2'b10, 1'b0, v[9:0], v[31:24]));
    push(mk(2'b10, 1'b1, v[9:0], 8'h00));
    push(mk(2'b01, 1'b0, v[25:16], v[15:8]));
    push(mk(2'b11, 1'b0, v[25:16], 8'hff));
    push(mk(2'b01, 1'b1, v[25:16], 8'h00));
    push(mk(2'b00, 1'b1, 10'h3ff, 8'h00));
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (rsp_q.size() < 5)
      @(negedge clk);
    repeat (2000) @(negedge clk);
    check("rsp_count", 32'(rsp_q.size()), 32'h5);
    check("acc_left", 32'(acc_q.size()), 32'h0);
    check("modes_ready", 32'({prg_mode, dev_mode, dev_ready}), 32'h7);
    for (int i = 0; i < 5; i++)
      check("rsp_word", rsp_q[i], exp_q[i]);
    $display("link test done");
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check("mode_off", 32'({prg_mode, dev_mode, dev_ready}), 32'h0);
    nrst = 1'b1;
    $display("reset test done");
    close_out();
  end
endmodule : serial_eeprom_programming_port_tb

`default_nettype wire
